/* File: dpio_defines.svh */
// register offsets, field positions and reset values for the dual parallel port block
`ifndef DPIO_DEFINES_SVH
`define DPIO_DEFINES_SVH
// printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define DPIO_IDX_F_LATCH 12'h440
`define DPIO_IDX_G_LATCH 12'h441
`define DPIO_IDX_G_DIR 12'h445
`define DPIO_IDX_F_DIR 12'h444
`define DPIO_IDX_ADC_SEL 12'h446
`define DPIO_ADDR_W 14
`define DPIO_DIR_RESET 8'h00
`define DPIO_ADC_SEL_RESET 4'h0
`define DPIO_ADC_EN_BIT 3
`define DPIO_TIMER_LSB 4
`endif

/* File: dpio_pkg.sv */
// types shared by the dual parallel port block
package dpio_pkg;
    // one port's register pair
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
    } dpio_port_regs_t;
    // pin driver bundle for one port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } dpio_pin_drive_t;
    typedef enum logic [1:0] {
        DPIO_SEL_NONE = 2'b00,
        DPIO_SEL_F_LATCH = 2'b01,
        DPIO_SEL_G_LATCH = 2'b10
    } dpio_unused_t;
endpackage

/* File: dpio_sync2.sv */
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
`default_nettype none
module dpio_sync2 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    // first stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: dpio_top.sv */
// dual 8-bit parallel port block with APB register access
//
// Functional notes
// [R1] two ports of eight pins, each pin with a writable latch bit
// [R2] latch contents are not touched by reset
// [R3] direction one enables the pin driver, zero disables it
// [R4] reset clears every direction bit of both ports
// [R5] first port data read returns latch where direction is one
// [R6] data read returns synchronised pin level where direction is zero
// [R7] latch bits accept writes whatever the direction
// [R8] writing an input pin's latch changes only the stored value
// [R9] timer edge/level select hands upper first-port pins to timer
// [R10] converter channel select forces chosen second-port pin to analog input
// [R11] unselected second-port pins stay ordinary digital I/O
// [R12] second port data register decoded at its own index, same read selection
// [R13] second port direction register at its own index, resets to zero
// [R14] software should load latch before turning a pin to output
// [R15] software should avoid digital reads of pins carrying analog voltage
// [R16] output pins drive latch value; registers update on the write strobe
`timescale 1ns/10ps
`default_nettype none
`include "dpio_defines.svh"
module dpio_top
    import dpio_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // first port pins, upper four shared with the second timer module
    input wire logic [7:0] first_port_pin_in,
    output logic [7:0] first_port_pin_out,
    output logic [7:0] first_port_pin_oe,
    // timer channel pins: per-channel edge/level select, drive and enable
    input wire logic [7:0] edge_level_select,
    input wire logic [3:0] timer_channel_out,
    input wire logic [3:0] timer_channel_oe,
    output logic [3:0] timer_channel_in,
    // second port pins, all shared with the converter
    input wire logic [7:0] second_port_pin_in,
    output logic [7:0] second_port_pin_out,
    output logic [7:0] second_port_pin_oe,
    // converter analog input selection, one-hot
    output logic [7:0] analog_input_pins
);
    // ==========================================================
    // elaboration checks
    // timer channels sit on the upper pins of the first port
    localparam int TIMER_PINS = 4;

    generate
        // register map, read mux and pin structs are all one byte wide
        if (PORT_W != 8) begin : g_bad_width
            $error("dpio_top supports only 8-bit ports");
        end
        // the shared timer pins must fit inside the first port
        if (`DPIO_TIMER_LSB + TIMER_PINS > PORT_W) begin : g_bad_timer
            $error("timer pins do not fit in the first port");
        end
    endgenerate

    // ==========================================================
    // decode helpers
    // register index from a byte address; words are aligned
    // the byte-lane bits are dropped here, alignment is checked by the caller
    function automatic logic [11:0] reg_index(input logic [31:0] addr);
        reg_index = addr[13:2];
    endfunction

    // latch where driven, pin where input
    function automatic logic [7:0] read_mix(input logic [7:0] latch,
                                            input logic [7:0] dir,
                                            input logic [7:0] pin);
        read_mix = (latch & dir) | (pin & ~dir);
    endfunction

    // ==========================================================
    // bus decode
    logic [11:0] idx;
    logic hit_f_latch;
    logic hit_g_latch;
    logic hit_f_dir;
    logic hit_g_dir;
    logic hit_adc;
    logic mapped;
    logic aligned;
    logic wr_en;
    logic rd_en;
    logic access;

    assign idx = reg_index(paddr);
    // upper address bits must be zero, so aliases of the map never hit a register
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[31:`DPIO_ADDR_W] == '0);
    assign hit_f_latch = aligned && (idx == `DPIO_IDX_F_LATCH);
    assign hit_g_latch = aligned && (idx == `DPIO_IDX_G_LATCH);
    assign hit_f_dir = aligned && (idx == `DPIO_IDX_F_DIR);
    assign hit_g_dir = aligned && (idx == `DPIO_IDX_G_DIR);
    assign hit_adc = aligned && (idx == `DPIO_IDX_ADC_SEL);
    // one hit per register; an unmapped index falls through to the error answer
    assign mapped = hit_f_latch | hit_g_latch | hit_f_dir | hit_g_dir | hit_adc;
    // access is the first access cycle only: masking with pready keeps a request
    // that is still held in the answer cycle from writing a second time
    assign access = psel && penable && !pready;
    assign wr_en = access && pwrite && pstrb[0] && mapped;
    assign rd_en = access && !pwrite;

    // per-register write strobes for the register processes below
    logic wr_f_latch;
    logic wr_g_latch;
    logic wr_f_dir;
    logic wr_g_dir;
    logic wr_adc;

    assign wr_f_latch = wr_en && hit_f_latch;
    assign wr_g_latch = wr_en && hit_g_latch;
    assign wr_f_dir = wr_en && hit_f_dir;
    assign wr_g_dir = wr_en && hit_g_dir;
    assign wr_adc = wr_en && hit_adc;

    // ==========================================================
    // register state
    // latch and direction sit in separate flops: the latches have no reset and the
    // direction bits do, so they cannot share one variable across two processes
    logic [7:0] f_latch_q;
    logic [7:0] g_latch_q;
    logic [7:0] f_dir_q;
    logic [7:0] g_dir_q;
    logic [3:0] adc_sel_q;
    dpio_port_regs_t port_f;
    dpio_port_regs_t port_g;

    // bundled views for the pin and read logic
    assign port_f = {f_latch_q, f_dir_q};
    assign port_g = {g_latch_q, g_dir_q};

    // [R1] [R2] eight-bit latches, not reset
    // no reset branch: a latch holds its value across reset, so it powers up unknown
    // and software has to load it before turning a pin to output
    // [R7] [R8] [R16] write on strobe
    always_ff @(posedge pclk) begin
        if (wr_f_latch) begin
            f_latch_q <= pwdata[7:0];
        end
        if (wr_g_latch) begin
            g_latch_q <= pwdata[7:0];
        end
    end

    // [R4] [R13] direction reset
    // every pin leaves reset as an input, so nothing is driven before software asks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f_dir_q <= `DPIO_DIR_RESET;
            g_dir_q <= `DPIO_DIR_RESET;
        end else begin
            if (wr_f_dir) begin
                f_dir_q <= pwdata[7:0];
            end
            if (wr_g_dir) begin
                g_dir_q <= pwdata[7:0];
            end
        end
    end

    // converter channel select: bit 3 enables, bits 2:0 pick the pin
    // with the enable clear every second-port pin stays digital
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_sel_q <= `DPIO_ADC_SEL_RESET;
        end else if (wr_adc) begin
            adc_sel_q <= pwdata[3:0];
        end
    end

    // ==========================================================
    // pin synchronisers
    // pins change with no regard to pclk: two flops stand before any logic reads them
    // [R6] these levels feed the read-back of input pins
    logic [7:0] f_pin_s;
    logic [7:0] g_pin_s;

    dpio_sync2 #(.WIDTH(8)) u_sync_f (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(first_port_pin_in),
        .sync_out(f_pin_s)
    );

    dpio_sync2 #(.WIDTH(8)) u_sync_g (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(second_port_pin_in),
        .sync_out(g_pin_s)
    );

    // ==========================================================
    // pin ownership
    logic [3:0] timer_own;
    logic [7:0] analog_own;
    dpio_pin_drive_t f_drive;
    dpio_pin_drive_t g_drive;

    // [R9] timer takes a pin when its select field is nonzero
    // a zero field hands the pin back to the port logic
    genvar ch;
    generate
        for (ch = 0; ch < TIMER_PINS; ch++) begin : g_timer
            assign timer_own[ch] = |edge_level_select[2*ch +: 2];
        end
    endgenerate

    // [R10] [R11] one-hot analog selection
    // only the selected pin is taken; the others stay ordinary digital pins
    always_comb begin
        analog_own = 8'h00;
        if (adc_sel_q[`DPIO_ADC_EN_BIT]) begin
            analog_own[adc_sel_q[2:0]] = 1'b1;
        end
    end

    // [R3] [R16] drive from latch, gated by direction
    always_comb begin
        f_drive.out = port_f.latch;
        f_drive.oe = port_f.dir;
        // [R9] timer overrides upper pins
        // the timer drives through its own enable, the direction bit has no say here
        for (int i = 0; i < TIMER_PINS; i++) begin
            if (timer_own[i]) begin
                f_drive.out[`DPIO_TIMER_LSB + i] = timer_channel_out[i];
                f_drive.oe[`DPIO_TIMER_LSB + i] = timer_channel_oe[i];
            end
        end
        g_drive.out = port_g.latch;
        // [R10] [R11] analog pin never driven, the rest follow their direction bits
        g_drive.oe = port_g.dir & ~analog_own;
    end

    // registered pin outputs; one cycle after the write strobe
    // reset parks every driver off; out levels do not matter while oe is low
    // timer channel inputs follow the synchronised pins whoever drives them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_port_pin_out <= 8'h00;
            first_port_pin_oe <= 8'h00;
            second_port_pin_out <= 8'h00;
            second_port_pin_oe <= 8'h00;
            timer_channel_in <= 4'h0;
            analog_input_pins <= 8'h00;
        end else begin
            first_port_pin_out <= f_drive.out;
            first_port_pin_oe <= f_drive.oe;
            second_port_pin_out <= g_drive.out;
            second_port_pin_oe <= g_drive.oe;
            timer_channel_in <= f_pin_s[7:4];
            analog_input_pins <= analog_own;
        end
    end

    // ==========================================================
    // read data
    logic [7:0] rd_mux;

    // [R5] [R6] [R12] latch-or-pin read
    // input pins come through the synchroniser, so a read sees them two cycles late
    // unmapped and unaligned reads fall through to zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit_f_latch) begin
            rd_mux = read_mix(port_f.latch, port_f.dir, f_pin_s);
        end else if (hit_g_latch) begin
            rd_mux = read_mix(port_g.latch, port_g.dir, g_pin_s);
        end else if (hit_f_dir) begin
            rd_mux = port_f.dir;
        end else if (hit_g_dir) begin
            rd_mux = port_g.dir;
        end else if (hit_adc) begin
            rd_mux = {4'h0, adc_sel_q};
        end
    end

    // pready pulses for one cycle, the cycle after the first access cycle
    // prdata is loaded only on reads, so it holds between them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && !mapped;
            if (rd_en) begin
                prdata <= {24'h00_0000, rd_mux};
            end
        end
    end
endmodule
`default_nettype wire

/* File: dpio_props.sv */
// assertion checker for the dual parallel port block, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module dpio_props #(
    parameter int PORT_W = 8
) (
    // clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and sharing controls
    input wire logic [7:0] first_port_pin_out,
    input wire logic [7:0] first_port_pin_oe,
    input wire logic [7:0] edge_level_select,
    input wire logic [3:0] timer_channel_out,
    input wire logic [3:0] timer_channel_oe,
    input wire logic [7:0] second_port_pin_oe,
    input wire logic [7:0] analog_input_pins
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // bus handshake
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    chk_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered in the next cycle");
    chk_bad_addr_err: assert property (
        pready && (paddr[31:14] != 18'h0 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped address answered without error");
    chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above the low byte not zero");
    // ==========
    // pin ownership
    chk_reset_inputs: assert property (
        $rose(presetn) |-> first_port_pin_oe == 8'h00 && second_port_pin_oe == 8'h00)
        else $error("a pin driver enabled out of reset");
    chk_timer_owns: assert property (
        $past(presetn) && $past(edge_level_select[1:0]) != 2'h0
        |-> first_port_pin_oe[4] == $past(timer_channel_oe[0])
        && first_port_pin_out[4] == $past(timer_channel_out[0]))
        else $error("timer-owned pin not driven by the timer");
    chk_analog_float: assert property ((analog_input_pins & second_port_pin_oe) == 8'h00)
        else $error("analog-selected pin still driven");
    chk_analog_onehot: assert property ($onehot0(analog_input_pins))
        else $error("more than one analog pin selected");
endmodule
bind dpio_top dpio_props #(.PORT_W(PORT_W)) i_dpio_props (.pclk, .presetn, .psel, .penable,
    .paddr, .prdata, .pready, .pslverr, .first_port_pin_out, .first_port_pin_oe,
    .edge_level_select, .timer_channel_out, .timer_channel_oe, .second_port_pin_oe,
    .analog_input_pins);
`default_nettype wire

/* File: dpio_pins.sv */
// pin-side model: resolves each pin from the driver enable and the outside level
`timescale 1ns/10ps
`default_nettype none
module dpio_pins (
    // drive from the block
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // level applied from outside on undriven pins
    input wire logic [7:0] ext_level,
    // level seen at the pins
    output logic [7:0] pin_level
);
    // ==========
    // pin resolution: an enabled driver wins over the outside source
    // driver shows its value
    assign pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

/* File: dpio_top_bench.sv */
// self-checking bench for the dual parallel port block over APB
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR %0t: got %h want %h", $time, a, e); end end
module dpio_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb, timer_channel_out, timer_channel_oe, timer_channel_in;
    logic [7:0] first_port_pin_in, first_port_pin_out, first_port_pin_oe, edge_level_select;
    logic [7:0] second_port_pin_in, second_port_pin_out, second_port_pin_oe, analog_input_pins;
    logic [7:0] ext_f, ext_g;
    int fail_count = 0;
    int check_count = 0;
    // byte addresses, four times the register index
    localparam logic [31:0] AF = 32'h1100, AG = 32'h1104, AFD = 32'h1110;
    localparam logic [31:0] AGD = 32'h1114, AAD = 32'h1118;
    dpio_top i_dpio_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .first_port_pin_in, .first_port_pin_out,
        .first_port_pin_oe, .edge_level_select, .timer_channel_out, .timer_channel_oe,
        .timer_channel_in, .second_port_pin_in, .second_port_pin_out, .second_port_pin_oe,
        .analog_input_pins);
    dpio_pins i_dpio_pins (.pin_out(first_port_pin_out), .pin_oe(first_port_pin_oe),
        .ext_level(ext_f), .pin_level(first_port_pin_in));
    dpio_pins i_dpio_pins_g (.pin_out(second_port_pin_out), .pin_oe(second_port_pin_oe),
        .ext_level(ext_g), .pin_level(second_port_pin_in));
    // ==========
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========
    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        // setup cycle: request, address, direction and data launched together
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle limit of its own: only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // write, then let pins and synchronisers settle
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {24'h0, d}, q, e);
        repeat (3) @(posedge pclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(q, {24'h0, x})
        `CHK(e, xe)
    endtask
    // ==========
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        edge_level_select = 8'h00;
        timer_channel_out = 4'h0;
        timer_channel_oe = 4'h0;
        ext_f = 8'hA5;
        ext_g = 8'h33;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(AFD, 8'h00, 1'b0);
        rd(AGD, 8'h00, 1'b0);
        rd(AF, 8'hA5, 1'b0);
        `CHK(timer_channel_in, 4'hA)
        wr(AF, 8'h3C);
        rd(AF, 8'hA5, 1'b0);
        `CHK(first_port_pin_oe, 8'h00)
        wr(AFD, 8'h0F);
        rd(AF, 8'hAC, 1'b0);
        `CHK(first_port_pin_oe, 8'h0F)
        `CHK(first_port_pin_out & 8'h0F, 8'h0C)
        wr(AG, 8'h5A);
        wr(AGD, 8'hF0);
        rd(AGD, 8'hF0, 1'b0);
        rd(AG, 8'h53, 1'b0);
        `CHK(second_port_pin_oe, 8'hF0)
        // no digital read of the second port while a channel is analog
        wr(AGD, 8'hFF);
        wr(AAD, 8'h0A);
        `CHK(analog_input_pins, 8'h04)
        `CHK(second_port_pin_oe, 8'hFB)
        wr(AAD, 8'h00);
        `CHK(second_port_pin_oe, 8'hFF)
        // timer takes channels 0 and 1, driving them to different levels
        edge_level_select <= 8'h05;
        timer_channel_out <= 4'h2;
        timer_channel_oe <= 4'h3;
        wr(AFD, 8'h00);
        `CHK(first_port_pin_oe, 8'h30)
        `CHK(first_port_pin_out[5:4], 2'b10)
        edge_level_select <= 8'h00;
        rd(32'h1108, 8'h00, 1'b1);
        rd(32'h1101, 8'h00, 1'b1);
        rd(32'h0001_1100, 8'h00, 1'b1);
        pstrb <= 4'h0;
        wr(AF, 8'hFF);
        pstrb <= 4'hF;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(AFD, 8'h00, 1'b0);
        wr(AFD, 8'hFF);
        rd(AF, 8'h3C, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
